// ---- rtcw_top.v ----
// Purpose: alarm match, watchdog, power-fail and irq pin of the rtc
// Assumes: timekeeping inputs are synchronous to core_clk
// Notes: registers over axi4-lite, byte address = 4 * register index
`include "rtcw_defs.vh"

module rtcw_top #(
    parameter [24:0] PULSE_CYCLES  = `RTCW_PULSE_MS * `RTCW_CLK_KHZ,
    parameter [24:0] RECALL_CYCLES = `RTCW_RECALL_MS * `RTCW_CLK_KHZ
) (
    // clock, reset, enable
    input  wire        core_clk,
    input  wire        reset_n,
    input  wire        clk_en,
    // axi4-lite write
    input  wire [19:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // axi4-lite read
    input  wire [19:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // timekeeping side
    input  wire        tk_sec_update,
    input  wire        tk_tick_32hz,
    input  wire        osc_running,
    input  wire        osc_failed_pu,
    input  wire [7:0]  tk_seconds,
    input  wire [7:0]  tk_minutes,
    input  wire [7:0]  tk_hours,
    input  wire [7:0]  tk_date,
    output wire        freeze_write,
    output wire        freeze_read,
    output wire        cal_out_en,
    // power monitor
    input  wire        vcc_ok_pin,
    output reg         store_req,
    output wire        backup_mode,
    // interrupt pin
    output reg         int_out,
    output reg         int_oe
);

    // power states, one-hot
    localparam [2:0] ST_RECALL = 3'b001;
    localparam [2:0] ST_RUN    = 3'b010;
    localparam [2:0] ST_BACKUP = 3'b100;

    // one-hot select of a mapped register, zero when unmapped
    function [7:0] reg_sel;
        input [19:0] a;
        reg   [16:0] ix;
        begin
            ix = a[18:2];
            reg_sel = 8'h00;
            if (a[1:0] == 2'b00 && a[19] == 1'b0) begin
                if (ix == `RTCW_IDX_FLAGS) reg_sel[0] = 1'b1;
                if (ix == `RTCW_IDX_ASEC)  reg_sel[2] = 1'b1;
                if (ix == `RTCW_IDX_AMIN)  reg_sel[3] = 1'b1;
                if (ix == `RTCW_IDX_AHOUR) reg_sel[4] = 1'b1;
                if (ix == `RTCW_IDX_ADATE) reg_sel[5] = 1'b1;
                if (ix == `RTCW_IDX_IRQ)   reg_sel[6] = 1'b1;
                if (ix == `RTCW_IDX_WDOG)  reg_sel[7] = 1'b1;
            end
        end
    endfunction

    // supply sync and power state
    reg        vcc_m_r;            // first sync stage
    reg        vcc_s_r;            // synchronised supply good
    reg [2:0]  pwr_st_r;           // power state
    reg [24:0] rec_cnt_r;          // recall delay counter
    // flags and control
    reg        wdf_r, af_r, pf_r, oscillator_failed_flag_r;
    reg        cal_r, w_r, r_r;
    reg        first_r;            // first cycle after release
    // interrupt config
    reg        wie_r, aie_r, pfe_r, hl_r, pl_r;
    // watchdog
    reg        wd_lock_r;          // timeout write lock
    reg [5:0]  wd_val_r;           // timeout value
    reg [5:0]  wd_cnt_r;           // down counter
    // alarm staging and active copies
    reg [7:0]  alm_stg_r [0:3];
    reg [7:0]  alm_act_r [0:3];
    // pulse generator
    reg        cond_d_r;           // source condition delayed
    reg [24:0] pls_cnt_r;          // pulse cycles left
    // bus holding
    reg        aw_hold_r, w_hold_r;
    reg [19:0] aw_addr_r;
    reg [31:0] w_data_r;
    reg        w_lane0_r;

    wire       run = (pwr_st_r == ST_RUN);
    assign backup_mode  = (pwr_st_r == ST_BACKUP);
    assign freeze_write = w_r;
    assign freeze_read  = r_r;
    assign cal_out_en   = cal_r;

    // bus handshakes
    assign s_axi_awready = ~aw_hold_r & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_hold_r & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;
    wire ar_go = s_axi_arvalid & s_axi_arready;
    wire wr_go = aw_hold_r & w_hold_r & ~s_axi_bvalid;

    // decoded accesses, registers hidden outside normal run
    wire [7:0] wsel = reg_sel(aw_addr_r);
    wire [7:0] rsel = reg_sel(s_axi_araddr);
    wire       wr_en = wr_go & run & w_lane0_r;
    wire [7:0] wd = w_data_r[7:0];
    wire       wr_flags = wr_en & wsel[0];
    wire       wr_irq   = wr_en & wsel[6];
    wire       wr_wdog  = wr_en & wsel[7];
    wire       rd_flags = ar_go & run & rsel[0];

    // alarm match per field, done as a loop over four fields
    wire [7:0] cur [0:3];
    assign cur[0] = tk_seconds;
    assign cur[1] = tk_minutes;
    assign cur[2] = tk_hours;
    assign cur[3] = tk_date;
    wire [3:0] fld_ok;
    wire [3:0] fld_off;                             // match bit per field
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_match
            // match bit one drops the field from the compare
            assign fld_off[g] = alm_act_r[g][`RTCW_A_M];
            assign fld_ok[g] = fld_off[g] |
                (alm_act_r[g][6:0] == cur[g][6:0]);
        end
    endgenerate
    // every field dropped means the alarm is switched off
    wire alm_hit = tk_sec_update & (&fld_ok) & ~(&fld_off);

    // watchdog expiry on the tick that takes it to zero
    wire wd_tick = tk_tick_32hz & osc_running &
        (wd_val_r != 6'h00);
    wire wd_strb = wr_wdog & wd[`RTCW_WD_STB];
    wire wd_hit  = wd_tick & ~wr_wdog & (wd_cnt_r <= 6'h01);

    // power-fail detect, only a loss seen from normal run
    wire pf_hit = ~vcc_s_r & run;

    // supply synchroniser and power state machine
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            vcc_m_r   <= 1'b0;
            vcc_s_r   <= 1'b0;
            pwr_st_r  <= ST_RECALL;
            rec_cnt_r <= 25'h0000000;
            store_req <= 1'b0;
        end else if (clk_en) begin
            vcc_m_r   <= vcc_ok_pin;
            vcc_s_r   <= vcc_m_r;
            store_req <= 1'b0;
            case (pwr_st_r)
                ST_RECALL: begin
                    // hold off access for the recall time
                    // supply not yet good, recall delay starts over
                    if (!vcc_s_r) begin
                        rec_cnt_r <= 25'h0000000;
                    end else if (rec_cnt_r >= RECALL_CYCLES - 25'h1) begin
                        pwr_st_r <= ST_RUN;
                    end else begin
                        rec_cnt_r <= rec_cnt_r + 25'h1;
                    end
                end
                ST_RUN: begin
                    // supply loss starts store, go to backup
                    if (!vcc_s_r) begin
                        pwr_st_r  <= ST_BACKUP;
                        store_req <= 1'b1;
                    end
                end
                ST_BACKUP: begin
                    // supply back, restart the recall delay
                    if (vcc_s_r) begin
                        pwr_st_r  <= ST_RECALL;
                        rec_cnt_r <= 25'h0000000;
                    end
                end
                default: pwr_st_r <= ST_RECALL;
            endcase
        end
    end

    // flags register, set beats read clear
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wdf_r   <= 1'b0;
            af_r    <= 1'b0;
            pf_r    <= 1'b0;
            oscillator_failed_flag_r  <= 1'b0;
            cal_r   <= 1'b0;
            w_r     <= 1'b0;
            r_r     <= 1'b0;
            first_r <= 1'b1;
        end else if (clk_en) begin
            first_r <= 1'b0;
            wdf_r <= (wdf_r & ~rd_flags) | wd_hit;
            af_r  <= (af_r & ~rd_flags) | alm_hit;
            pf_r  <= (pf_r & ~rd_flags) | pf_hit;
            // oscillator flag caught after release
            if (first_r)
                oscillator_failed_flag_r <= osc_failed_pu;
            else if (rd_flags)
                oscillator_failed_flag_r <= 1'b0;
            else if (wr_flags & w_r & ~wd[`RTCW_F_OSCILLATOR_FAILED_FLAG])
                oscillator_failed_flag_r <= 1'b0;
            // control bits are not flags, reads keep them
            if (wr_flags) begin
                cal_r <= wd[`RTCW_F_CAL];
                w_r   <= wd[`RTCW_F_W];
                r_r   <= wd[`RTCW_F_R];
            end
        end
    end

    // interrupt config register
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wie_r <= 1'b0;
            aie_r <= 1'b0;
            pfe_r <= 1'b0;
            hl_r  <= 1'b1;
            pl_r  <= 1'b0;
        end else if (clk_en && wr_irq) begin
            wie_r <= wd[`RTCW_I_WIE];
            aie_r <= wd[`RTCW_I_AIE];
            pfe_r <= wd[`RTCW_I_PFE];
            hl_r  <= wd[`RTCW_I_HL];
            pl_r  <= wd[`RTCW_I_PL];
        end
    end

    // watchdog timeout, lock and down counter
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wd_lock_r <= 1'b0;
            wd_val_r  <= `RTCW_WDT_RST;
            wd_cnt_r  <= `RTCW_WDT_RST;
        end else if (clk_en) begin
            if (wr_wdog) begin
                wd_lock_r <= wd[`RTCW_WD_LOCK];
                if (!wd[`RTCW_WD_LOCK]) begin
                    // new value also reloads the counter
                    wd_val_r <= wd[5:0];
                    wd_cnt_r <= wd[5:0];
                end else if (wd_strb) begin
                    wd_cnt_r <= wd_val_r;
                end
            end else if (wd_tick) begin
                // expiry reloads, count runs on
                if (wd_cnt_r <= 6'h01)
                    wd_cnt_r <= wd_val_r;
                else
                    wd_cnt_r <= wd_cnt_r - 6'h01;
            end
        end
    end

    // alarm staging, copied to active when freeze drops
    integer i;
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (i = 0; i < 4; i = i + 1) begin
                alm_stg_r[i] <= `RTCW_ALM_RST;
                alm_act_r[i] <= `RTCW_ALM_RST;
            end
        end else if (clk_en) begin
            for (i = 0; i < 4; i = i + 1) begin
                if (wr_en & w_r & wsel[i+2])
                    alm_stg_r[i] <= wd;
                if (w_r & wr_flags & ~wd[`RTCW_F_W])
                    alm_act_r[i] <= alm_stg_r[i];
            end
        end
    end

    // enabled sources, gated to normal supply
    wire cond = run & ((wdf_r & wie_r) |
                       (af_r & aie_r) |
                       (pf_r & pfe_r));
    wire active = pl_r ? (pls_cnt_r != 25'h0000000) : cond;

    // pulse generator, started on a new enabled source
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cond_d_r  <= 1'b0;
            pls_cnt_r <= 25'h0000000;
        end else if (clk_en) begin
            cond_d_r <= cond;
            if (rd_flags || !run)
                pls_cnt_r <= 25'h0000000;
            else if (pl_r && cond && !cond_d_r)
                pls_cnt_r <= PULSE_CYCLES;
            else if (pls_cnt_r != 25'h0000000)
                pls_cnt_r <= pls_cnt_r - 25'h1;
        end
    end

    // pin driver, registered
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            int_out <= 1'b0;
            int_oe  <= 1'b0;
        end else if (clk_en) begin
            if (hl_r) begin
                // push-pull, only while above switchover
                int_out <= active & run;
                int_oe  <= run;
            end else begin
                // open drain, pull low while active
                int_out <= 1'b0;
                int_oe  <= active & run;
            end
        end
    end

    // read data mux
    reg [7:0] rd_byte;
    always @* begin
        rd_byte = 8'h00;
        if (rsel[0])
            rd_byte = {wdf_r, af_r, pf_r, oscillator_failed_flag_r, 1'b0, cal_r, w_r, r_r};
        if (rsel[2]) rd_byte = alm_stg_r[0];
        if (rsel[3]) rd_byte = alm_stg_r[1];
        if (rsel[4]) rd_byte = alm_stg_r[2];
        if (rsel[5]) rd_byte = alm_stg_r[3];
        if (rsel[6])
            rd_byte = {wie_r, aie_r, pfe_r, 1'b0, hl_r, pl_r, 2'b00};
        if (rsel[7])
            rd_byte = {1'b0, wd_lock_r, wd_val_r};
    end

    // write channels, taken in either order
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            aw_hold_r    <= 1'b0;
            w_hold_r     <= 1'b0;
            aw_addr_r    <= 20'h00000;
            w_data_r     <= 32'h00000000;
            w_lane0_r    <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RTCW_OKAY;
        end else if (clk_en) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_r  <= 1'b1;
                w_data_r  <= s_axi_wdata;
                w_lane0_r <= s_axi_wstrb[0];
            end
            if (wr_go) begin
                // both halves held, answer the write
                aw_hold_r    <= 1'b0;
                w_hold_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (run && wsel != 8'h00) ?
                                `RTCW_OKAY : `RTCW_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read channel, answer one cycle after address
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `RTCW_OKAY;
        end else if (clk_en) begin
            if (ar_go) begin
                s_axi_rvalid <= 1'b1;
                if (run && rsel != 8'h00) begin
                    s_axi_rdata <= {24'h000000, rd_byte};
                    s_axi_rresp <= `RTCW_OKAY;
                end else begin
                    // hidden or unmapped reads as zero
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= `RTCW_SLVERR;
                end
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule // rtcw_top

// ---- rtcw_defs.vh ----
// Purpose: shared constants of the rtc alarm/watchdog/irq block
// Assumes: register index = printed offset, byte address = 4 * index
// Notes: times are in ms, cycle counts derive from the clock rate
`ifndef RTCW_DEFS_VH
`define RTCW_DEFS_VH
// register indices
`define RTCW_IDX_FLAGS 17'h1fff0
`define RTCW_IDX_ASEC  17'h1fff2
`define RTCW_IDX_AMIN  17'h1fff3
`define RTCW_IDX_AHOUR 17'h1fff4
`define RTCW_IDX_ADATE 17'h1fff5
`define RTCW_IDX_IRQ   17'h1fff6
`define RTCW_IDX_WDOG  17'h1fff7
// flags register bits
`define RTCW_F_WDF  7
`define RTCW_F_AF   6
`define RTCW_F_PF   5
`define RTCW_F_OSCILLATOR_FAILED_FLAG 4
`define RTCW_F_CAL  2
`define RTCW_F_W    1
`define RTCW_F_R    0
// irq config bits
`define RTCW_I_WIE 7
`define RTCW_I_AIE 6
`define RTCW_I_PFE 5
`define RTCW_I_HL  3
`define RTCW_I_PL  2
// watchdog control bits
`define RTCW_WD_STB  7
`define RTCW_WD_LOCK 6
// alarm match-select bit
`define RTCW_A_M 7
// reset values
`define RTCW_ALM_RST 8'h80
`define RTCW_IRQ_RST 8'h08
`define RTCW_WDT_RST 6'h00
// timing
`define RTCW_CLK_KHZ   25'd100000
`define RTCW_PULSE_MS  25'd200
`define RTCW_RECALL_MS 25'd20
// bus responses
`define RTCW_OKAY   2'b00
`define RTCW_SLVERR 2'b10
`endif

// ---- rtcw_props.sv ----
// Purpose: concurrent checks on the rtc irq pin, backup and bus answers
// Assumes: irq register writes offer address and data in the same cycle
// Notes: pin mode is tracked from irq register writes seen on the bus
`include "rtcw_defs.vh"
module rtcw_props #(
    parameter [24:0] PULSE_CYCLES = 25'd20
) (
    // clock and reset
    input wire        core_clk,
    input wire        reset_n,
    // register bus
    input wire [19:0] s_axi_awaddr,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0]  s_axi_wstrb,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire        s_axi_bvalid,
    input wire [19:0] s_axi_araddr,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [1:0]  s_axi_rresp,
    input wire        s_axi_rvalid,
    // events and power
    input wire        tk_sec_update,
    input wire        tk_tick_32hz,
    input wire        vcc_ok_pin,
    input wire        store_req,
    input wire        backup_mode,
    // interrupt pin
    input wire        int_out,
    input wire        int_oe
);
    localparam [19:0] FLG = {1'b0, `RTCW_IDX_FLAGS, 2'b00};
    localparam [19:0] IRQ = {1'b0, `RTCW_IDX_IRQ, 2'b00};
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    wire rd_flags = s_axi_arvalid && s_axi_arready && s_axi_araddr == FLG;
    wire wr_irq = s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
                  s_axi_wready && s_axi_awaddr == IRQ && s_axi_wstrb[0];
    reg        hl_r;      // active high push-pull mode
    reg        pl_r;      // pulse mode
    reg [24:0] act_cnt_r; // cycles the pin has been active
    wire pin_act = hl_r ? int_out : int_oe;
    // shadow of the pin mode bits
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            hl_r      <= 1'b1;
            pl_r      <= 1'b0;
            act_cnt_r <= 25'h0;
        end else begin
            if (wr_irq) begin
                hl_r <= s_axi_wdata[3];
                pl_r <= s_axi_wdata[2];
            end
            act_cnt_r <= pin_act ? act_cnt_r + 25'h1 : 25'h0;
        end
    end
    AST_BACKUP_QUIET: assert property (backup_mode && $past(backup_mode)
        |-> !int_oe && !int_out) else $error("pin driven on backup");
    AST_BACKUP_SLVERR: assert property (s_axi_arvalid && s_axi_arready
        && backup_mode |=> s_axi_rresp == `RTCW_SLVERR)
        else $error("register visible on backup");
    AST_STORE_ONE: assert property (store_req |=> !store_req)
        else $error("store request longer than one cycle");
    AST_STORE_ENTRY: assert property ($rose(backup_mode)
        |-> store_req || $past(store_req)) else $error("backup without store");
    AST_PIN_DRIVE: assert property (int_out |-> int_oe && hl_r)
        else $error("pin driven high in open drain mode");
    AST_READ_CLEARS: assert property (rd_flags && !tk_sec_update &&
        !tk_tick_32hz && vcc_ok_pin |-> ##2 !pin_act)
        else $error("pin still active after flags read");
    AST_LEVEL_HOLDS: assert property (pin_act && !pl_r && vcc_ok_pin &&
        !backup_mode && !s_axi_bvalid && !s_axi_rvalid && !rd_flags
        |=> pin_act) else $error("level interrupt dropped early");
    AST_PULSE_MAX: assert property (pl_r && pin_act
        |-> act_cnt_r < PULSE_CYCLES) else $error("pulse too long");
endmodule // rtcw_props
bind rtcw_top rtcw_props #(.PULSE_CYCLES(PULSE_CYCLES)) u_props (
    .core_clk(core_clk), .reset_n(reset_n), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .tk_sec_update(tk_sec_update), .tk_tick_32hz(tk_tick_32hz),
    .vcc_ok_pin(vcc_ok_pin), .store_req(store_req),
    .backup_mode(backup_mode), .int_out(int_out), .int_oe(int_oe));

// ---- rtcw_host_model.sv ----
// Purpose: host side of the interrupt pin, with pull-up and recall mask
// Assumes: pull-up returns to the supply, so it falls with vcc
// Notes: host_hl is the polarity the host programmed
module rtcw_host_model #(
    parameter int IGNORE_CYCLES = 16
) (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic reset_n,
    // supply and host setting
    input  wire logic vcc_ok_pin,
    input  wire logic host_hl,
    // pin driver of the block
    input  wire logic int_out,
    input  wire logic int_oe,
    // resolved pin and host view
    output wire logic int_pin,
    output wire logic irq_seen
);
    int wait_r; // cycles since power up
    // released pin floats to the pull-up, which follows the supply
    assign int_pin = int_oe ? int_out : vcc_ok_pin;
    // pin activity ignored until recall has surely finished
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) wait_r <= 0;
        else if (wait_r < IGNORE_CYCLES) wait_r <= wait_r + 1;
    end
    assign irq_seen = (wait_r == IGNORE_CYCLES) &&
                      (host_hl ? int_pin : !int_pin);
endmodule // rtcw_host_model

// ---- tb.sv ----
// Purpose: self-checking bench for the rtc alarm, watchdog and irq block
// Assumes: short pulse and recall counts set by parameter
// Notes: all bus traffic goes through wr and rd
`include "rtcw_defs.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int RECALL = 10;
    localparam [19:0] A_FLG = 20'h7ffc0, A_BAD = 20'h7ffc4;
    localparam [19:0] A_SEC = 20'h7ffc8, A_MIN = 20'h7ffcc;
    localparam [19:0] A_HR = 20'h7ffd0, A_DT = 20'h7ffd4;
    localparam [19:0] A_IRQ = 20'h7ffd8, A_WD = 20'h7ffdc;
    logic core_clk, reset_n, clk_en, host_hl;
    logic [19:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_rready;
    logic [31:0] s_axi_wdata;
    logic [3:0] s_axi_wstrb;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid;
    wire s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    logic tk_sec_update, tk_tick_32hz, osc_running, osc_failed_pu;
    logic vcc_ok_pin;
    logic [7:0] tk_seconds, tk_minutes, tk_hours, tk_date;
    wire freeze_write, freeze_read, cal_out_en, store_req, backup_mode;
    wire int_out, int_oe, int_pin, irq_seen;
    int miscompares = 0, cmp_count = 0;
    logic [7:0] rd_d; // last read byte
    logic [1:0] resp; // last response
    rtcw_top #(.PULSE_CYCLES(25'd20), .RECALL_CYCLES(25'd10)) DUT (
        .core_clk, .reset_n, .clk_en, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tk_sec_update,
        .tk_tick_32hz, .osc_running, .osc_failed_pu, .tk_seconds,
        .tk_minutes, .tk_hours, .tk_date, .freeze_write, .freeze_read,
        .cal_out_en, .vcc_ok_pin, .store_req, .backup_mode, .int_out,
        .int_oe);
    rtcw_host_model u_host (.core_clk, .reset_n, .vcc_ok_pin, .host_hl,
        .int_out, .int_oe, .int_pin, .irq_seen);
    // compare one byte-wide result
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // bus write, valids dropped as each channel is taken
    task automatic wr(input logic [19:0] a, input logic [7:0] d);
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    // bus read of one register
    task automatic rd(input logic [19:0] a);
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd_d = s_axi_rdata[7:0];
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // one seconds update, then three idle cycles
    task automatic sec(input logic [7:0] s);
        @(posedge core_clk);
        tk_seconds <= s;
        tk_sec_update <= 1'b1;
        @(posedge core_clk);
        tk_sec_update <= 1'b0;
        tick(3);
    endtask
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge core_clk);
            tk_tick_32hz <= 1'b1;
            @(posedge core_clk);
            tk_tick_32hz <= 1'b0;
        end
        tick(3);
    endtask
    // power-up contents and an unmapped index
    task automatic t_reset;
        rd(A_IRQ); chk(rd_d, `RTCW_IRQ_RST);
        rd(A_WD); chk(rd_d, {2'b00, `RTCW_WDT_RST});
        rd(A_SEC); chk(rd_d, `RTCW_ALM_RST);
        rd(A_FLG); chk(rd_d, 8'h10);
        rd(A_FLG); chk(rd_d, 8'h00);
        rd(A_BAD); chk({6'h0, resp}, {6'h0, `RTCW_SLVERR});
    endtask
    // alarm staged under freeze, match fields, level active low
    task automatic t_alarm;
        wr(A_FLG, 8'h07);
        chk({5'h0, cal_out_en, freeze_write, freeze_read}, 8'h07);
        wr(A_SEC, 8'h05);
        wr(A_MIN, 8'h10); wr(A_HR, 8'h80); wr(A_DT, 8'h80);
        wr(A_IRQ, 8'h40); host_hl <= 1'b0;
        tk_minutes <= 8'h10; sec(8'h05);
        rd(A_FLG); chk(rd_d, 8'h07);
        wr(A_FLG, 8'h00); tk_minutes <= 8'h11; sec(8'h05);
        rd(A_FLG); chk(rd_d, 8'h00);
        tk_minutes <= 8'h10; sec(8'h05);
        chk({7'h0, irq_seen}, 8'h01);
        chk({7'h0, int_pin}, 8'h00);
        tick(6); rd(A_FLG); chk(rd_d, 8'h40);
        tick(2); chk({7'h0, irq_seen}, 8'h00);
        rd(A_FLG); chk(rd_d, 8'h00);
    endtask
    // watchdog in pulse mode, lock, strobe, stopped oscillator
    task automatic t_wdog;
        wr(A_IRQ, 8'h8c); host_hl <= 1'b1;
        wr(A_WD, 8'h03); ticks(2);
        osc_running <= 1'b0; ticks(3); osc_running <= 1'b1;
        clk_en <= 1'b0; ticks(2); clk_en <= 1'b1;
        rd(A_FLG); chk(rd_d, 8'h00);
        wr(A_WD, 8'hc0); ticks(2);
        rd(A_FLG); chk(rd_d, 8'h00);
        ticks(1); chk({7'h0, irq_seen}, 8'h01);
        rd(A_FLG); chk(rd_d, 8'h80);
        tick(2); chk({7'h0, irq_seen}, 8'h00);
        ticks(3); chk({7'h0, irq_seen}, 8'h01);
        tick(25); chk({7'h0, irq_seen}, 8'h00);
        rd(A_WD); chk(rd_d, 8'h43);
        rd(A_FLG); wr(A_IRQ, 8'h0c); ticks(3);
        chk({7'h0, irq_seen}, 8'h00);
        rd(A_FLG); chk(rd_d, 8'h80);
        wr(A_WD, 8'h00); ticks(8);
        rd(A_FLG); chk(rd_d, 8'h00);
    endtask
    // supply loss, backup, return through recall
    task automatic t_power;
        logic seen;
        seen = 1'b0;
        wr(A_IRQ, 8'h28);
        vcc_ok_pin <= 1'b0;
        repeat (10) begin
            @(posedge core_clk);
            if (store_req === 1'b1) seen = 1'b1;
        end
        chk({7'h0, seen}, 8'h01);
        chk({6'h0, backup_mode, int_oe}, 8'h02);
        rd(A_FLG); chk({6'h0, resp}, {6'h0, `RTCW_SLVERR});
        vcc_ok_pin <= 1'b1; tick(RECALL + 6);
        chk({7'h0, irq_seen}, 8'h01);
        rd(A_FLG); chk(rd_d, 8'h20);
    endtask
    task automatic wrap_up;
        if (miscompares == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // hang guard, far beyond the few hundred cycles the tests need
    initial begin
        #100000;
        miscompares++;
        wrap_up;
    end
    initial begin
        reset_n = 1'b0; clk_en = 1'b1; host_hl = 1'b1;
        s_axi_awaddr = 20'h0; s_axi_araddr = 20'h0; s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf; s_axi_awvalid = 1'b0; s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0; s_axi_arvalid = 1'b0; s_axi_rready = 1'b0;
        tk_sec_update = 1'b0; tk_tick_32hz = 1'b0; osc_running = 1'b1;
        osc_failed_pu = 1'b1; vcc_ok_pin = 1'b1; tk_seconds = 8'h00;
        tk_minutes = 8'h11; tk_hours = 8'h12; tk_date = 8'h01;
        tick(12);
        reset_n <= 1'b1;
        tick(RECALL + 8);
        t_reset;
        t_alarm;
        t_wdog;
        t_power;
        wrap_up;
    end
endmodule // tb
